//--- inc/binary_pkg.sv
/*
 package of constants shared by the trailing-edge binary elements.
 assumes one core clock; the element clock is a level from core-clock logic.
*/
// How it works
// RQ1 - clock low: slave copies master, data inputs blocked from master
// RQ2 - clock high: master loads inputs, slave isolated from master
// RQ3 - output changes only after the falling edge; inputs locked out there
// RQ4 - the plain gated latch is transparent while high; unfit for clocking
// RQ5 - steered variant: data inputs active low, low level arms that side
// RQ6 - steered variant: falling edge drives armed side high, then holds
// RQ7 - j-k with both inputs active complements at the edge, else like r-s
// RQ8 - driving logic never raises reset and set together at an edge
// RQ9 - delay element shows the input held at the edge, one period later
// RQ10 - toggle element: hold or complement only, j and k tied together
// RQ11 - no active input at an edge keeps the stored state
package binary_pkg;
   localparam int NUM_KINDS = 5;
   localparam int KIND_RS = 0;
   localparam int KIND_STEER = 1;
   localparam int KIND_JK = 2;
   localparam int KIND_D = 3;
   localparam int KIND_T = 4;
   localparam logic STATE_RESET = 1'h0;
   // element clock idles low; a matching history avoids a false fall
   localparam logic CLK_IDLE = 1'h0;
endpackage

//--- design/master_slave_cell.sv
/*
 one master-slave storage bit.
 assumes the caller flags clock-high cycles and the falling-edge cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module master_slave_cell (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_high,
   input wire logic clk_fall,
   input wire logic master_in,
   output logic q
);
   typedef struct packed {
      logic master;
      logic slave;
   } cell_state_t;

   cell_state_t state;
   cell_state_t next_state;

   always_comb begin
      next_state = state;
      // RQ2 master loads while high
      if (clk_high) begin
         next_state.master = master_in;
      end
      // RQ1 slave takes master on low
      // only the fall cycle can move it, since master is frozen while low
      if (clk_fall) begin
         next_state.slave = state.master;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{master: binary_pkg::STATE_RESET,
                    slave: binary_pkg::STATE_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign q = state.slave;
endmodule // master_slave_cell
`default_nettype wire

//--- design/trailing_edge_binary_elements.sv
/*
 r-s, steered r-s, j-k, d and t binaries, all trailing-edge triggered,
 plus a plain gated latch for comparison.
 assumes elem_clk and data come from logic on core_clk; no synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none
module trailing_edge_binary_elements (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic elem_clk,
   input wire logic rs_reset,
   input wire logic rs_set,
   input wire logic steer_reset_n,
   input wire logic steer_set_n,
   input wire logic jk_j,
   input wire logic jk_k,
   input wire logic d_in,
   input wire logic t_in,
   output logic q_rs,
   output logic q_steer,
   output logic q_jk,
   output logic q_d,
   output logic q_t,
   output logic q_latch
);
   typedef struct packed {
      logic clk_prev;
      logic latch;
   } top_state_t;

   top_state_t state;
   top_state_t next_state;
   logic clk_high;
   logic clk_fall;
   logic [binary_pkg::NUM_KINDS-1:0] master_in;
   logic [binary_pkg::NUM_KINDS-1:0] q;

   assign clk_high = elem_clk;
   // RQ3 falling edge detect
   // inputs in this cycle are already ignored: the clock is low
   assign clk_fall = state.clk_prev & ~elem_clk;

   always_comb begin
      next_state = state;
      next_state.clk_prev = elem_clk;
      // RQ4 transparent gated latch
      // every input change while high reaches the output: not for counters
      if (elem_clk && rs_set && !rs_reset) begin
         next_state.latch = 1'h1;
      end else if (elem_clk && rs_reset && !rs_set) begin
         next_state.latch = 1'h0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{clk_prev: binary_pkg::CLK_IDLE,
                    latch: binary_pkg::STATE_RESET};
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      master_in = q;
      // RQ8 forbidden pair holds
      // both active is the driver's fault; holding is the safe answer
      if (rs_set && !rs_reset) begin
         master_in[binary_pkg::KIND_RS] = 1'h1;
      end else if (rs_reset && !rs_set) begin
         master_in[binary_pkg::KIND_RS] = 1'h0;
      end
      // RQ5 active-low arming
      // RQ6 armed side wins
      // both armed is forbidden too, so it holds like the r-s pair
      if (!steer_set_n && steer_reset_n) begin
         master_in[binary_pkg::KIND_STEER] = 1'h1;
      end else if (!steer_reset_n && steer_set_n) begin
         master_in[binary_pkg::KIND_STEER] = 1'h0;
      end
      // RQ7 j-k complement case
      case ({jk_j, jk_k})
         2'h3: master_in[binary_pkg::KIND_JK] = ~q[binary_pkg::KIND_JK];
         2'h2: master_in[binary_pkg::KIND_JK] = 1'h1;
         2'h1: master_in[binary_pkg::KIND_JK] = 1'h0;
         // RQ11 no input holds
         default: master_in[binary_pkg::KIND_JK] = q[binary_pkg::KIND_JK];
      endcase
      // RQ9 delay element input
      master_in[binary_pkg::KIND_D] = d_in;
      // RQ10 toggle as tied j-k
      master_in[binary_pkg::KIND_T] = q[binary_pkg::KIND_T] ^ t_in;
   end

   genvar g;
   generate
      for (g = 0; g < binary_pkg::NUM_KINDS; g++) begin : g_cell
         master_slave_cell u_cell (
            .core_clk(core_clk),
            .rst(rst),
            .clk_high(clk_high),
            .clk_fall(clk_fall),
            .master_in(master_in[g]),
            .q(q[g])
         );
      end
   endgenerate

   assign q_rs = q[binary_pkg::KIND_RS];
   assign q_steer = q[binary_pkg::KIND_STEER];
   assign q_jk = q[binary_pkg::KIND_JK];
   assign q_d = q[binary_pkg::KIND_D];
   assign q_t = q[binary_pkg::KIND_T];
   assign q_latch = state.latch;

   // the last high cycle decides what the master holds at the fall
   sequence last_high_then_fall;
      elem_clk ##1 !elem_clk;
   endsequence

   sequence low_then_low;
      !elem_clk ##1 !elem_clk;
   endsequence

   sequence reset_armed_at_fall;
      (!steer_reset_n && steer_set_n) ##0 last_high_then_fall;
   endsequence

   sequence steer_idle_at_fall;
      (steer_reset_n && steer_set_n) ##0 last_high_then_fall;
   endsequence

   // RQ3 outputs move after fall only
   only_after_fall_a: assert property ( // RQ3
      @(posedge core_clk) disable iff (rst)
      (q != $past(q)) |-> $past(clk_fall))
      else $error("element output changed without a falling edge");

   // RQ6 steered output holds
   steer_holds_a: assert property ( // RQ6
      @(posedge core_clk) disable iff (rst)
      !clk_fall |=> $stable(q_steer))
      else $error("steered output moved between edges");

   // RQ6 armed side set
   steer_set_a: assert property ( // RQ6
      @(posedge core_clk) disable iff (rst)
      (!steer_set_n && steer_reset_n) ##0 last_high_then_fall |=> q_steer)
      else $error("armed set side not high after falling edge");

   // RQ5 reset side armed
   steer_reset_a: assert property ( // RQ5
      @(posedge core_clk) disable iff (rst)
      reset_armed_at_fall |=> !q_steer)
      else $error("armed reset side did not clear steered output");

   // RQ5 high inputs disarm
   steer_idle_a: assert property ( // RQ5
      @(posedge core_clk) disable iff (rst)
      steer_idle_at_fall |=> $stable(q_steer))
      else $error("steered output moved with no side armed");

   // RQ2 r-s set at edge
   rs_set_a: assert property ( // RQ2
      @(posedge core_clk) disable iff (rst)
      (rs_set && !rs_reset) ##0 last_high_then_fall |=> q_rs)
      else $error("r-s element did not set at falling edge");

   // RQ2 r-s reset at edge
   rs_reset_a: assert property ( // RQ2
      @(posedge core_clk) disable iff (rst)
      (rs_reset && !rs_set) ##0 last_high_then_fall |=> !q_rs)
      else $error("r-s element did not reset at falling edge");

   // RQ2 r-s idle holds
   rs_hold_a: assert property ( // RQ2
      @(posedge core_clk) disable iff (rst)
      (!rs_reset && !rs_set) ##0 last_high_then_fall |=> $stable(q_rs))
      else $error("r-s element changed with no active input");

   // RQ2 slave isolated while high
   high_isolated_a: assert property ( // RQ2
      @(posedge core_clk) disable iff (rst)
      elem_clk |=> $stable(q))
      else $error("element output moved while clock was high");

   // RQ1 inputs blocked while low
   low_blocked_a: assert property ( // RQ1
      @(posedge core_clk) disable iff (rst)
      low_then_low |=> $stable(q))
      else $error("element output moved while clock stayed low");

   // RQ7 j-k complements
   jk_toggle_a: assert property ( // RQ7
      @(posedge core_clk) disable iff (rst)
      (jk_j && jk_k) ##0 last_high_then_fall |=> q_jk != $past(q_jk))
      else $error("j-k element did not complement");

   // RQ7 j alone sets
   jk_set_a: assert property ( // RQ7
      @(posedge core_clk) disable iff (rst)
      (jk_j && !jk_k) ##0 last_high_then_fall |=> q_jk)
      else $error("j-k element did not set");

   // RQ7 k alone resets
   jk_reset_a: assert property ( // RQ7
      @(posedge core_clk) disable iff (rst)
      (!jk_j && jk_k) ##0 last_high_then_fall |=> !q_jk)
      else $error("j-k element did not reset");

   // RQ11 j-k holds
   jk_hold_a: assert property ( // RQ11
      @(posedge core_clk) disable iff (rst)
      (!jk_j && !jk_k) ##0 last_high_then_fall |=> $stable(q_jk))
      else $error("j-k element changed with no active input");

   // RQ9 delay element follows
   d_follow_a: assert property ( // RQ9
      @(posedge core_clk) disable iff (rst)
      last_high_then_fall |=> q_d == $past(d_in, 2))
      else $error("delay element output differs from sampled input");

   // RQ10 toggle complements
   t_toggle_a: assert property ( // RQ10
      @(posedge core_clk) disable iff (rst)
      t_in ##0 last_high_then_fall |=> q_t != $past(q_t))
      else $error("toggle element did not complement");

   // RQ10 toggle idle holds
   t_hold_a: assert property ( // RQ10
      @(posedge core_clk) disable iff (rst)
      !t_in ##0 last_high_then_fall |=> $stable(q_t))
      else $error("toggle element changed with no active input");

   // RQ4 latch is transparent
   latch_open_a: assert property ( // RQ4
      @(posedge core_clk) disable iff (rst)
      (elem_clk && rs_set && !rs_reset) |=> q_latch)
      else $error("gated latch did not pass set while open");

   // RQ4 latch passes reset
   latch_clear_a: assert property ( // RQ4
      @(posedge core_clk) disable iff (rst)
      (elem_clk && rs_reset && !rs_set) |=> !q_latch)
      else $error("gated latch did not pass reset while open");

   // RQ4 latch shut while low
   latch_shut_a: assert property ( // RQ4
      @(posedge core_clk) disable iff (rst)
      !elem_clk |=> $stable(q_latch))
      else $error("gated latch moved while its control was low");

endmodule // trailing_edge_binary_elements
`default_nettype wire

//--- bench/clock_source.sv
/*
 driving logic: makes elem_clk pulses and the r-s request lines.
 assumes start and wants come from bench logic on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_source (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [3:0] high_len,
   input wire logic want_reset,
   input wire logic want_set,
   output logic elem_clk,
   output logic rs_reset,
   output logic rs_set
);
   logic [3:0] left;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         left <= 4'h0;
         elem_clk <= 1'b0;
      end else if (start && !elem_clk) begin
         left <= high_len;
         elem_clk <= 1'b1;
      end else if (left > 4'h1) begin
         left <= left - 4'h1;
      end else begin
         left <= 4'h0;
         elem_clk <= 1'b0;
      end
   end
   assign rs_reset = want_reset;
   assign rs_set = want_set & ~want_reset;
endmodule // clock_source
`default_nettype wire

//--- bench/tb.sv
/*
 self-checking bench for the trailing-edge binaries.
 assumes clock_source drives elem_clk and the r-s lines.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [3:0] high_len = 4'h1;
   logic want_reset = 1'b0;
   logic want_set = 1'b0;
   logic sr_n = 1'b1;
   logic ss_n = 1'b1;
   logic j = 1'b0;
   logic k = 1'b0;
   logic d = 1'b0;
   logic t = 1'b0;
   logic elem_clk, rs_r, rs_s, q_rs, q_steer, q_jk, q_d, q_t, q_latch;
   int n_fail = 0;
   int n_compared = 0;
   always #5 core_clk = ~core_clk;
   clock_source src (.core_clk(core_clk), .rst(rst), .start(start),
      .high_len(high_len), .want_reset(want_reset), .want_set(want_set),
      .elem_clk(elem_clk), .rs_reset(rs_r), .rs_set(rs_s));
   trailing_edge_binary_elements uut (.core_clk(core_clk), .rst(rst),
      .elem_clk(elem_clk), .rs_reset(rs_r), .rs_set(rs_s),
      .steer_reset_n(sr_n), .steer_set_n(ss_n), .jk_j(j), .jk_k(k),
      .d_in(d), .t_in(t), .q_rs(q_rs), .q_steer(q_steer), .q_jk(q_jk),
      .q_d(q_d), .q_t(q_t), .q_latch(q_latch));
   task automatic chk(input logic seen, input logic exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task automatic pulse(input logic [3:0] n);
      @(posedge core_clk);
      high_len <= n;
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (n + 3) @(posedge core_clk);
   endtask
   task automatic test_delay();
      @(posedge core_clk);
      d <= 1'b1;
      @(posedge core_clk);
      high_len <= 4'h4;
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(q_d, 1'b0, "d moved while high");
      @(posedge core_clk);
      d <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(q_d, 1'b1, "d value at edge");
      repeat (3) @(posedge core_clk);
      chk(q_d, 1'b1, "d taken while low");
      $display("test delay done");
   endtask
   task automatic test_sync();
      // {reset,set,steer_r_n,steer_s_n,j,k,t}; row 1 holds all, rows 3,4 hold r-s and steered
      logic [6:0] in_v [5] = '{7'h35, 7'h18, 7'h4B, 7'h1F, 7'h1F};
      logic [3:0] ex [5] = '{4'hF, 4'hF, 4'h0, 4'h3, 4'h0};
      for (int i = 0; i < 5; i++) begin
         {want_reset, want_set, sr_n, ss_n, j, k, t} <= in_v[i];
         pulse(4'h1);
         chk(q_rs, ex[i][3], "r-s");
         chk(q_steer, ex[i][2], "steered");
         chk(q_jk, ex[i][1], "j-k");
         chk(q_t, ex[i][0], "toggle");
      end
      {want_reset, want_set, sr_n, ss_n, j, k, t} <= 7'h18;
      $display("test sync done");
   endtask
   task automatic test_latch();
      @(posedge core_clk);
      want_set <= 1'b1;
      high_len <= 4'h8;
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(q_latch, 1'b1, "latch set");
      chk(q_rs, 1'b0, "r-s early");
      want_reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(q_latch, 1'b0, "latch reset");
      want_reset <= 1'b0;
      want_set <= 1'b0;
      repeat (6) @(posedge core_clk);
      $display("test latch done");
   endtask
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      chk(q_rs | q_steer | q_jk | q_d | q_t | q_latch, 1'b0, "reset");
      test_delay();
      test_sync();
      test_latch();
      give_verdict();
   end
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
endmodule // tb
`default_nettype wire
